// file: hw/pwm_period_duty_generator.sv
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - period is (period_reg+1) x 4 x prescale clocks
// - timer clears after matching period_reg
// - output set at rollover unless duty zero
// - rollover copies duty into shadow and latch
// - postscaler never touches the pwm period
// - duty is write byte plus control bits 5:4
// - high time is duty x prescale clocks
// - duty writes apply only after period ends
// - shadow register read-only in pwm mode
// - shadow plus hidden latch double buffer duty
// - output clears on extended timer duty match
// - duty beyond period keeps output high
// - cleared control forces output latch low
// - resolution up to ten bits by frequency
// - timer prescale 1:1, 1:4 or 1:16
// - period_reg resets to all ones
// - clearing timer_run stops the timer
module pwm_period_duty_generator
    import pwm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            pwm_out_pin_o,
    output logic            pwm_out_pin_oe_o,
    output logic            postscale_evt_o
);
    logic [7:0] period_r;
    logic [7:0] timer_count_r;
    logic [7:0] duty_high_write_r;
    logic [7:0] duty_high_shadow_r;
    logic [7:0] control_r;
    logic [7:0] timer_ctrl_r;
    logic [7:0] port_direction_r;
    logic [1:0] duty_low_latch_r;
    logic [1:0] phase_r;
    logic [3:0] presc_r;
    logic [3:0] post_r;
    logic       pwm_latch_r;
    logic       post_evt_r;
    logic [7:0] rdata_r;
    presc_t     presc_sel;
    logic       presc_done;
    logic       inc_tick;
    logic       rollover;
    logic       pwm_mode;
    logic [1:0] fine_bits;
    logic [9:0] duty_buf;
    logic [9:0] duty_next;
    logic       duty_match;
    logic       wr_timer;
    logic       fine_step;
    logic [2:0] presc_shift;
    logic [9:0] ext_next;

    assign pwm_mode = (control_r[MODE_HI:MODE_PWM_LO] == 2'h3);
    assign wr_timer = wr_i && (addr_i == TIMER_OFS);

    always_comb begin
        unique case (timer_ctrl_r[PRESC_HI:PRESC_LO])
            2'h0:    presc_sel = PRESC_1;
            2'h1:    presc_sel = PRESC_4;
            default: presc_sel = PRESC_16;
        endcase
    end

    always_comb begin
        unique case (presc_sel)
            PRESC_1: begin
                presc_done  = 1'b1;
                fine_bits   = phase_r;
                fine_step   = 1'b1;
                presc_shift = 3'h0;
            end
            PRESC_4: begin
                presc_done  = (presc_r[1:0] == 2'h3);
                fine_bits   = presc_r[1:0];
                fine_step   = (phase_r == PHASE_LAST);
                presc_shift = 3'h2;
            end
            PRESC_16: begin
                presc_done  = (presc_r == 4'hf);
                fine_bits   = presc_r[3:2];
                fine_step   = (phase_r == PHASE_LAST)
                              && (presc_r[1:0] == 2'h3);
                presc_shift = 3'h4;
            end
        endcase
    end

    assign inc_tick = timer_ctrl_r[RUN_BIT] && (phase_r == PHASE_LAST)
                      && presc_done;
    // match with period_reg ends the period
    assign rollover = inc_tick && (timer_count_r == period_r);

    // ten-bit duty from write byte and control bits
    assign duty_next = {duty_high_write_r,
                        control_r[DUTY_LSB_HI:DUTY_LSB_LO]};
    assign duty_buf  = {duty_high_shadow_r, duty_low_latch_r};
    // compare against timer plus two fine bits
    // full ten-bit compare resolution
    // match looks one fine step ahead, else the pin stays up one
    // fine step (prescale clocks) too long after the last counted step
    assign ext_next   = {timer_count_r, fine_bits} + 10'h001;
    assign duty_match = timer_ctrl_r[RUN_BIT] && fine_step
                        && (duty_buf == ext_next);

    // instruction phase counter, Fosc/4
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // prescaler stages; cleared with the timer so phases line up
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            presc_r <= PRESC_RST;
        end else if (wr_timer) begin
            presc_r <= PRESC_RST;
        end else if (timer_ctrl_r[RUN_BIT] && phase_r == PHASE_LAST) begin
            presc_r <= presc_r + 4'h1;
        end
    end

    // timer cleared at reset; wraps after period_reg
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_count_r <= TIMER_RST;
        end else if (wr_timer) begin
            timer_count_r <= wdata_i;
        end else if (rollover) begin
            timer_count_r <= TIMER_RST;
        end else if (inc_tick) begin
            timer_count_r <= timer_count_r + 8'h01;
        end
    end

    // postscaler only paces its own event
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            post_r     <= POST_RST;
            post_evt_r <= 1'b0;
        end else begin
            post_evt_r <= 1'b0;
            if (rollover) begin
                if (post_r == timer_ctrl_r[POST_HI:POST_LO]) begin
                    post_r     <= POST_RST;
                    post_evt_r <= 1'b1;
                end else begin
                    post_r <= post_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            period_r <= PERIOD_RST;
        end else if (wr_i && addr_i == PERIOD_OFS) begin
            period_r <= wdata_i;
        end
    end

    // duty writes land in the write side at any time
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            duty_high_write_r <= DUTY_RST;
            control_r         <= CONTROL_RST;
            timer_ctrl_r      <= TIMER_CTRL_RST;
            port_direction_r  <= PORT_DIR_RST;
        end else if (wr_i) begin
            unique case (addr_i)
                DUTY_WRITE_OFS: duty_high_write_r <= wdata_i;
                CONTROL_OFS:    control_r    <= wdata_i & CONTROL_MASK;
                TIMER_CTRL_OFS: timer_ctrl_r <= wdata_i & TIMER_CTRL_MSK;
                PORT_DIR_OFS:   port_direction_r <= wdata_i;
                default: ;
            endcase
        end
    end

    // rollover loads shadow and hidden latch together
    // double buffer keeps mid-period edits glitch free
    // software writes to shadow ignored in pwm mode
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            duty_high_shadow_r <= DUTY_RST;
            duty_low_latch_r   <= 2'h0;
        end else if (pwm_mode && rollover) begin
            duty_high_shadow_r <= duty_next[9:2];
            duty_low_latch_r   <= duty_next[1:0];
        end else if (!pwm_mode && wr_i && addr_i == DUTY_SHADOW_OFS) begin
            duty_high_shadow_r <= wdata_i;
        end
    end

    // output latch; set on rollover wins over a same-edge clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pwm_latch_r <= 1'b0;
        end else if (control_r == CONTROL_RST || !pwm_mode) begin
            pwm_latch_r <= 1'b0;
        end else if (rollover) begin
            // set unless the new duty is zero
            pwm_latch_r <= (duty_next != 10'h000);
        end else if (duty_match) begin
            // duty past the period never matches
            pwm_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                PERIOD_OFS:      rdata_r <= period_r;
                TIMER_OFS:       rdata_r <= timer_count_r;
                DUTY_WRITE_OFS:  rdata_r <= duty_high_write_r;
                DUTY_SHADOW_OFS: rdata_r <= duty_high_shadow_r;
                CONTROL_OFS:     rdata_r <= control_r;
                TIMER_CTRL_OFS:  rdata_r <= timer_ctrl_r;
                PORT_DIR_OFS:    rdata_r <= port_direction_r;
                default:         rdata_r <= 8'h00;
            endcase
        end
    end

    assign rdata_o          = rdata_r;
    assign pwm_out_pin_o    = pwm_latch_r;
    // pin drives only while direction bit is clear
    assign pwm_out_pin_oe_o = !port_direction_r[PIN_DIR_BIT];
    assign postscale_evt_o  = post_evt_r;

    // ---------------- assertions ----------------
    logic [15:0] per_cnt_r;
    logic        clean_r;
    logic [15:0] per_len;
    logic [15:0] hi_len;

    // clocks since the last rollover, saturating while stopped
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            per_cnt_r <= 16'h0000;
        end else if (rollover) begin
            per_cnt_r <= 16'h0001;
        end else if (per_cnt_r != 16'hffff) begin
            per_cnt_r <= per_cnt_r + 16'h0001;
        end
    end

    // any timer setup write spoils the timing of the running period
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            clean_r <= 1'b0;
        end else if (wr_timer || (wr_i && (addr_i == PERIOD_OFS
                     || addr_i == TIMER_CTRL_OFS))) begin
            clean_r <= 1'b0;
        end else if (rollover) begin
            clean_r <= 1'b1;
        end
    end

    assign per_len = ({8'h00, period_r} + 16'h0001)
                     << (presc_shift + 3'h2);
    assign hi_len  = {6'h00, duty_buf} << presc_shift;

    timer_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rollover && !wr_timer |=> timer_count_r == 8'h00)
        else $error("timer did not wrap after period match");

    pin_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rollover && pwm_mode && duty_next != 10'h000 |=> pwm_out_pin_o)
        else $error("pin not set at rollover");

    zero_duty_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rollover && duty_next == 10'h000 |=> !pwm_out_pin_o)
        else $error("pin set with zero duty");

    duty_latch_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rollover && pwm_mode |=> duty_buf == $past(duty_next))
        else $error("duty not latched at rollover");

    duty_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        pwm_mode && !rollover && $past(pwm_mode) |=> $stable(duty_buf))
        else $error("buffered duty moved mid-period");

    pin_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        pwm_mode && control_r != 8'h00 && !rollover && duty_match
        |=> !pwm_out_pin_o)
        else $error("pin not cleared on duty match");

    ctrl_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        control_r == 8'h00 |=> !pwm_out_pin_o)
        else $error("pin high with control cleared");

    run_stop_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !timer_ctrl_r[RUN_BIT] && !wr_timer |=> $stable(timer_count_r))
        else $error("timer moved while stopped");

    idle_mode_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !pwm_mode |=> !pwm_out_pin_o)
        else $error("pin active outside pwm mode");

    period_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rollover && clean_r |-> per_cnt_r == per_len)
        else $error("period length wrong");

    high_time_a: assert property (@(posedge clk_i) disable iff (reset_i)
        pwm_mode && pwm_latch_r && duty_match && !rollover && clean_r
        |-> per_cnt_r == hi_len)
        else $error("high time wrong");

    cover_pwm_pulse_c: cover property (@(posedge clk_i) disable iff (reset_i)
        pwm_out_pin_o ##1 !pwm_out_pin_o);
    cover_full_high_c: cover property (@(posedge clk_i) disable iff (reset_i)
        rollover && pwm_out_pin_o);
    cover_postscale_c: cover property (@(posedge clk_i) disable iff (reset_i)
        postscale_evt_o);
endmodule

// file: hw/pwm_pkg.sv
package pwm_pkg;
    // register indices on the plain register port
    localparam logic [2:0] PERIOD_OFS      = 3'h0;
    localparam logic [2:0] TIMER_OFS       = 3'h1;
    localparam logic [2:0] DUTY_WRITE_OFS  = 3'h2;
    localparam logic [2:0] DUTY_SHADOW_OFS = 3'h3;
    localparam logic [2:0] CONTROL_OFS     = 3'h4;
    localparam logic [2:0] TIMER_CTRL_OFS  = 3'h5;
    localparam logic [2:0] PORT_DIR_OFS    = 3'h6;

    // capture_pwm_control fields
    localparam int DUTY_LSB_HI  = 5;
    localparam int DUTY_LSB_LO  = 4;
    localparam int MODE_HI      = 3;
    localparam int MODE_PWM_LO  = 2;
    // timer control fields
    localparam int POST_HI      = 6;
    localparam int POST_LO      = 3;
    localparam int RUN_BIT      = 2;
    localparam int PRESC_HI     = 1;
    localparam int PRESC_LO     = 0;
    // pin direction bit of port_direction
    localparam int PIN_DIR_BIT  = 2;

    localparam logic [7:0] PERIOD_RST     = 8'hff;
    localparam logic [7:0] TIMER_RST      = 8'h00;
    localparam logic [7:0] DUTY_RST       = 8'h00;
    localparam logic [7:0] CONTROL_RST    = 8'h00;
    localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
    localparam logic [7:0] PORT_DIR_RST   = 8'hff;
    localparam logic [7:0] CONTROL_MASK   = 8'h3f;
    localparam logic [7:0] TIMER_CTRL_MSK = 8'h7f;

    // last oscillator clock of the four-clock instruction cycle
    localparam logic [1:0] PHASE_LAST     = 2'h3;
    localparam logic [3:0] PRESC_RST      = 4'h0;
    localparam logic [3:0] POST_RST       = 4'h0;

    typedef enum logic [2:0] {
        PRESC_1  = 3'b001,
        PRESC_4  = 3'b010,
        PRESC_16 = 3'b100
    } presc_t;
endpackage

// file: bench/pwm_load.sv
`timescale 1ns/1ps
module pwm_load (
    input  wire logic        clk_i,
    input  wire logic        pin_i,
    input  wire logic        oe_i,
    input  wire logic        arm_i,
    output logic             done_o,
    output logic      [15:0] hi_o,
    output logic      [15:0] per_o
);
    logic       lvl;
    logic       lvl_r;
    logic [1:0] st_r;

    // an undriven pin reads low through the pull-down of the load
    assign lvl = oe_i ? pin_i : 1'b0;

    // one high time and one rise-to-rise period per arming
    always_ff @(posedge clk_i) begin
        lvl_r  <= lvl;
        done_o <= 1'b0;
        if (!arm_i) begin
            st_r <= 2'h0;
        end else if (st_r == 2'h0) begin
            if (lvl && !lvl_r) begin
                st_r  <= 2'h1;
                hi_o  <= 16'h0001;
                per_o <= 16'h0001;
            end
        end else if (st_r == 2'h1) begin
            if (lvl && !lvl_r) begin
                st_r   <= 2'h2;
                done_o <= 1'b1;
            end else begin
                per_o <= per_o + 16'h0001;
                if (lvl) begin
                    hi_o <= hi_o + 16'h0001;
                end
            end
        end
    end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
    import pwm_pkg::*;
    logic        clk_i   = 1'b0;
    logic        reset_i = 1'b1;
    logic [2:0]  addr_i  = 3'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic        arm     = 1'b0;
    logic        rd_d    = 1'b0;
    logic [7:0]  lf      = 8'h54;
    logic [7:0]  rdata_o;
    logic        pwm_out_pin_o;
    logic        pwm_out_pin_oe_o;
    logic        done;
    logic        post_evt;
    int          np;
    logic [15:0] hi;
    logic [15:0] per;
    logic [7:0]  rq[$];
    logic [31:0] pq[$];
    int          mismatches = 0;
    int          n_tests    = 0;
    int          cycles     = 0;
    int          pr;
    int          du;
    int          f;

    always #25 clk_i = ~clk_i;

    pwm_period_duty_generator u_pwm_period_duty_generator (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pwm_out_pin_o(pwm_out_pin_o), .pwm_out_pin_oe_o(pwm_out_pin_oe_o),
        .postscale_evt_o(post_evt));

    pwm_load u_pwm_load (
        .clk_i(clk_i), .pin_i(pwm_out_pin_o), .oe_i(pwm_out_pin_oe_o),
        .arm_i(arm), .done_o(done), .hi_o(hi), .per_o(per));

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // strobes stay up between back-to-back accesses
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        rd_i    <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        rq.push_back(e);
        addr_i <= a;
        rd_i   <= 1'b1;
        wr_i   <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic cyc(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask

    task automatic meas(input int h, input int p);
        int k;
        pq.push_back({16'(h), 16'(p)});
        arm <= 1'b1;
        for (k = 0; k < 3000 && done !== 1'b1; k++) cyc(1);
        arm <= 1'b0;
        cyc(1);
    endtask

    task automatic hic(input int n, input int e, input string nm);
        int c;
        c  = 0;
        np = 0;
        cyc(0);
        repeat (n) begin
            @(posedge clk_i);
            if (pwm_out_pin_o === 1'b1) c++;
            if (post_evt === 1'b1) np++;
        end
        chk(nm, 32'(e), 32'(c));
    endtask

    // results are taken off the queues in the order they were noted
    always @(posedge clk_i) begin
        if (rd_d) chk("rdata", {24'h0, rq.pop_front()}, {24'h0, rdata_o});
        if (done === 1'b1) chk("pulse", pq.pop_front(), {hi, per});
        rd_d <= rd_i;
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(PERIOD_OFS, PERIOD_RST);
        rd(TIMER_OFS, 8'h00);
        wr(3'h7, 8'h5a);
        rd(3'h7, 8'h00);
        wr(PORT_DIR_OFS, 8'hfb);
        cyc(1);
        chk("pin_oe", 32'h1, {31'h0, pwm_out_pin_oe_o});
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            pr = int'(lf[2:0]);
            f  = (i == 0) ? 1 : (i == 1) ? 4 : 16;
            lf = lfsr(lf);
            du = int'(lf) % ((pr + 1) * 4 - 1) + 1;
            wr(PERIOD_OFS, 8'(pr));
            wr(DUTY_WRITE_OFS, 8'(du >> 2));
            wr(CONTROL_OFS, {2'h0, 2'(du), 4'hc});
            lf = lfsr(lf);
            // random postscale must leave the period alone
            wr(TIMER_CTRL_OFS, {1'b0, lf[3:0], 1'b1, 2'(i)});
            cyc(8 * (pr + 1) * f + 8);
            meas(du * f, (pr + 1) * 4 * f);
        end
        wr(TIMER_CTRL_OFS, 8'h00);
        wr(TIMER_OFS, 8'h00);
        wr(DUTY_WRITE_OFS, 8'h01);
        cyc(10);
        rd(TIMER_OFS, 8'h00);
        rd(DUTY_SHADOW_OFS, 8'(du >> 2));
        wr(DUTY_SHADOW_OFS, 8'haa);
        rd(DUTY_SHADOW_OFS, 8'(du >> 2));
        wr(TIMER_CTRL_OFS, 8'h04);
        cyc(8 * (pr + 1) + 8);
        rd(DUTY_SHADOW_OFS, 8'h01);
        wr(DUTY_WRITE_OFS, 8'h00);
        wr(CONTROL_OFS, 8'h0c);
        cyc(8 * (pr + 1) + 8);
        hic(100, 0, "zero_duty");
        wr(DUTY_WRITE_OFS, 8'hff);
        cyc(8 * (pr + 1) + 8);
        hic(128, 128, "long_duty");
        chk("postscale", 32'h4, 32'(np));
        wr(CONTROL_OFS, 8'h38);
        cyc(2);
        hic(40, 0, "other_mode");
        wr(CONTROL_OFS, 8'h0c);
        cyc(8 * (pr + 1) + 8);
        wr(CONTROL_OFS, 8'h00);
        cyc(2);
        hic(40, 0, "cleared_ctrl");
        cyc(4);
        end_sim();
    end
endmodule
